/* bench/wlu_storage_model.sv */
// Storage subsystem model answering word loads
`timescale 1ns/1ps
module wlu_storage_model (
  // Clock
  input  wire        clock_i,
  // Request from the unit
  input  wire        req_i,
  // Behaviour commanded by the bench
  input  wire [31:0] word_i,
  input  wire [1:0]  fault_i,
  input  wire [3:0]  wait_i,
  // Answer
  output reg         ack_o,
  output reg  [31:0] data_o,
  output reg  [1:0]  fault_o
);
  reg [3:0] cnt;
  initial {ack_o, data_o, fault_o, cnt} = 0;
  // Ack after wait_i idle cycles; data scrambled when not answering
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    fault_o <= 2'h0;
    data_o <= ~data_o;
    if (req_i && !ack_o) begin
      cnt <= (cnt == wait_i) ? 4'h0 : cnt + 4'h1;
      if (cnt == wait_i) begin
        ack_o <= 1'b1;
        data_o <= word_i;
        fault_o <= fault_i;
      end
    end
  end
endmodule // wlu_storage_model

/* bench/wlu_top_chk.sv */
// Port checker for the word-load unit
`timescale 1ns/1ps
module wlu_top_chk (
  input wire        clock_i,
  input wire        rst_i,
  input wire        mode64_i,
  input wire        issue_valid_i,
  input wire [31:0] instr_i,
  input wire        issue_ready_o,
  input wire        mem_req_o,
  input wire        mem_ack_i,
  input wire        mem_align_fault_i,
  input wire        mem_dsi_fault_i,
  input wire        cond_done_i,
  input wire        resv_valid_o,
  input wire        dest_we_o,
  input wire        base_we_o,
  input wire        illegal_o,
  input wire        fixed_point_exception_we_o,
  input wire        cr0_we_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Issue taken, then a clean or faulting answer
  sequence s_take; issue_valid_i && issue_ready_o; endsequence
  sequence s_ok; mem_req_o && mem_ack_i && !mem_align_fault_i && !mem_dsi_fault_i; endsequence
  sequence s_bad; mem_req_o && mem_ack_i && (mem_align_fault_i || mem_dsi_fault_i); endsequence
  disp_req_a: assert property (s_take ##0 instr_i[31:26] == 6'h20 |=> mem_req_o)
    else $error("no request after displacement load");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o)
    else $error("request dropped before ack");
  busy_ready_a: assert property (mem_req_o |-> !issue_ready_o)
    else $error("ready while busy");
  wb_after_ack_a: assert property (s_ok |=> dest_we_o && !mem_req_o)
    else $error("no writeback after ack");
  no_fault_upd_a: assert property (s_bad |=> !base_we_o)
    else $error("base update despite fault");
  flags_kept_a: assert property (!fixed_point_exception_we_o && !cr0_we_o)
    else $error("flag register written");
  illegal_32_a: assert property (s_take ##0 !mode64_i && instr_i[31:26] == 6'h1F && instr_i[10:1] == 10'h155
    |=> !mem_req_o ##[0:1] illegal_o)
    else $error("algebraic load not illegal");
  resv_clear_a: assert property (cond_done_i && !mem_req_o |=> !resv_valid_o)
    else $error("reservation kept after store");
endmodule // wlu_top_chk
bind wlu_top wlu_top_chk u_wlu_top_chk (.*);

/* bench/word_load_instruction_unit_test.sv */
// Testbench for the word-load unit
`timescale 1ns/1ps
module word_load_instruction_unit_test;
  reg clock_i = 0, rst_i = 1, mode64 = 1, iv = 0, snoop = 0, cdone = 0;
  reg [31:0] instr = 0, word = 0;
  reg [63:0] caddr = 0, ea, dd, bwd;
  reg [1:0] flt = 0;
  reg [3:0] wt = 0;
  reg bwe, ill;
  wire [4:0] breg, xreg, dreg, bwreg;
  wire [31:0] mdata;
  wire [1:0] mflt;
  wire ack, req, rdy, cok, rv, dwe, bwe_w, ill_w, flt_w;
  wire [63:0] eaw, ddw, bwdw;
  integer n_mismatch = 0, samples_checked = 0;
  always #2 clock_i = ~clock_i;
  // Register file: value grows with number, r0 nonzero to expose misuse
  function [63:0] gpr(input [4:0] r);
    gpr = {56'h0, r, 3'h0} + 64'h1_0000_0000;
  endfunction
  function [31:0] xf(input [9:0] xo, input [4:0] d, b, x);
    xf = {6'h1F, d, b, x, xo, 1'b0};
  endfunction
  wlu_top u_wlu_top (.clock_i(clock_i), .rst_i(rst_i), .mode64_i(mode64), .issue_valid_i(iv), .instr_i(instr),
    .issue_ready_o(rdy), .base_register_o(breg), .index_register_o(xreg), .base_data_i(gpr(breg)),
    .index_data_i(gpr(xreg)), .mem_req_o(req), .effective_address_o(eaw), .mem_ack_i(ack), .mem_data_i(mdata),
    .mem_align_fault_i(mflt[1]), .mem_dsi_fault_i(mflt[0]), .snoop_wr_i(snoop), .snoop_addr_i(caddr),
    .cond_done_i(cdone), .cond_addr_i(caddr), .cond_ok_o(cok), .resv_valid_o(rv), .dest_we_o(dwe),
    .dest_register_o(dreg), .dest_data_o(ddw), .base_we_o(bwe_w), .base_wr_register_o(bwreg),
    .base_wr_data_o(bwdw), .illegal_o(ill_w), .fault_o(flt_w), .fixed_point_exception_we_o(), .cr0_we_o());
  wlu_storage_model u_wlu_storage_model (.clock_i(clock_i), .req_i(req), .word_i(word), .fault_i(flt),
    .wait_i(wt), .ack_o(ack), .data_o(mdata), .fault_o(mflt));
  task chk(input ok);
    begin
      samples_checked = samples_checked + 1;
      if (!ok) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t mismatch", $time);
      end
    end
  endtask
  // One issue, then wait for its outcome
  task op(input [31:0] ins, input [31:0] w, input [1:0] f, input [3:0] n);
    integer i;
    begin
      word = w; flt = f; wt = n; instr = ins; iv = 1; ea = 0;
      @(posedge clock_i); #1 iv = 0;
      for (i = 0; i < 20 && !(dwe === 1 || ill_w === 1 || flt_w === 1); i = i + 1) begin
        if (req === 1) ea = eaw;
        @(posedge clock_i); #1;
      end
      dd = ddw; bwe = bwe_w; bwd = bwdw; ill = ill_w;
      // No outcome within the limit counts against the run
      if (i == 20) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t no outcome", $time);
      end
    end
  endtask
  task t_reserve;
    begin
      op(xf(10'h014, 5'h3, 5'h0, 5'h5), 32'h8000_0001, 2'h0, 4'h3);
      chk(ea === gpr(5'h5) && dreg === 5'h3);
      chk(dd[31:0] === 32'h8000_0001 && rv === 1);
      caddr = ea; #1 chk(cok === 1);
      // Foreign write to the neighbouring word keeps the reservation
      @(posedge clock_i); #1 caddr = ea + 64'h4; snoop = 1;
      #1 chk(cok === 0);
      @(posedge clock_i); #1 chk(rv === 1);
      snoop = 0; cdone = 1; caddr = ea;
      @(posedge clock_i); #1 cdone = 0; chk(rv === 0);
      // Second reservation lost to a foreign write of the same word
      op(xf(10'h014, 5'h3, 5'h0, 5'h9), 32'h1234_5678, 2'h0, 4'h0);
      chk(dd[31:0] === 32'h1234_5678 && rv === 1);
      caddr = ea; snoop = 1; #1 chk(cok === 0);
      @(posedge clock_i); #1 snoop = 0; chk(rv === 0);
      $display("t_reserve done");
    end
  endtask
  task t_alg;
    begin
      op(xf(10'h175, 5'h4, 5'h6, 5'h2), 32'h8765_4321, 2'h0, 4'h0);
      chk(ea === gpr(5'h6) + gpr(5'h2) && dd === 64'hFFFF_FFFF_8765_4321);
      chk(bwe === 1 && bwd === ea && bwreg === 5'h6 && dreg === 5'h4);
      op(xf(10'h155, 5'h4, 5'h0, 5'h7), 32'h7000_0002, 2'h0, 4'h2);
      chk(ea === gpr(5'h7) && dd === 64'h0000_0000_7000_0002);
      op(xf(10'h175, 5'h8, 5'h6, 5'h2), 32'h1, 2'h1, 4'h1);
      chk(bwe === 0 && flt_w === 1 && dwe === 0);
      mode64 = 0;
      op(xf(10'h155, 5'h4, 5'h6, 5'h2), 32'h1, 2'h0, 4'h0);
      chk(ill === 1 && ea === 0);
      mode64 = 1;
      $display("t_alg done");
    end
  endtask
  task t_brev_disp;
    begin
      op(xf(10'h216, 5'h6, 5'h4, 5'h5), 32'h0000_FFFF, 2'h0, 4'h1);
      chk(ea === gpr(5'h4) + gpr(5'h5) && dd === 64'h0000_0000_FFFF_0000);
      op({6'h20, 5'h7, 5'h9, 16'hFFF8}, 32'h8000_0000, 2'h0, 4'h0);
      chk(ea === gpr(5'h9) - 64'h8 && dd === 64'h0000_0000_8000_0000);
      op({6'h20, 5'h7, 5'h0, 16'h7FF0}, 32'h5, 2'h0, 4'h2);
      chk(ea === 64'h7FF0);
      $display("t_brev_disp done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #20000 n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clock_i);
    #1 rst_i = 0;
    t_reserve;
    t_alg;
    t_brev_disp;
    close_out;
  end
endmodule // word_load_instruction_unit_test

/* rtl/wlu_decode.v */
// Opcode decoder for the word-load family
`timescale 1ns/1ps
`include "wlu_defs.vh"
module wlu_decode (
  // Instruction and configuration
  input  wire [31:0] instr_i,
  input  wire        mode64_i,
  // Decoded kind, at most one set
  output wire        is_reserve_o,
  output wire        is_alg_upd_o,
  output wire        is_alg_idx_o,
  output wire        is_brev_o,
  output wire        is_disp_o,
  output wire        illegal_o
);
  wire       op_x;
  wire [9:0] xo;
  wire       alg_upd_raw;
  wire       alg_idx_raw;

  // Field matches
  assign op_x         = (instr_i[`WLU_F_OP] == `WLU_OP_X);
  assign xo           = instr_i[`WLU_F_XO];
  assign is_reserve_o = op_x && (xo == `WLU_XO_RESERVE);               // RQ1
  assign alg_upd_raw  = op_x && (xo == `WLU_XO_ALG_UPD) && !instr_i[`WLU_F_RC]; // RQ7
  assign alg_idx_raw  = op_x && (xo == `WLU_XO_ALG_IDX) && !instr_i[`WLU_F_RC]; // RQ11
  assign is_alg_upd_o = alg_upd_raw && mode64_i;                       // RQ13
  assign is_alg_idx_o = alg_idx_raw && mode64_i;                       // RQ13
  assign is_brev_o    = op_x && (xo == `WLU_XO_BREV);                  // RQ14
  assign is_disp_o    = (instr_i[`WLU_F_OP] == `WLU_OP_DISP);          // RQ17
  assign illegal_o    = (alg_upd_raw || alg_idx_raw) && !mode64_i;     // RQ13
endmodule // wlu_decode

/* rtl/wlu_defs.vh */
// Constants for the word-load instruction unit
// Behaviour
// [RQ1] Load-reserve: primary 31, extended 20
// [RQ2] Reserve address: index, plus base if nonzero
// [RQ3] Load-reserve writes word, sets reservation
// [RQ4] Conditional store only if reservation intact
// [RQ5] Software supplies word-aligned reserve address
// [RQ6] Load-reserve leaves exception register unchanged
// [RQ7] Algebraic update: primary 31, extended 373, bit31 zero
// [RQ8] Algebraic loads sign-extend word to 64
// [RQ9] Algebraic update writes address to base
// [RQ10] Software avoids base zero or base equals dest
// [RQ11] Algebraic indexed: primary 31, extended 341
// [RQ12] Algebraic indexed address: index plus nonzero base
// [RQ13] Algebraic loads illegal on 32-bit implementation
// [RQ14] Byte-reverse: extended 534, indexed address
// [RQ15] Byte-reverse swaps the four bytes
// [RQ16] Byte-reverse, displacement leave flags unchanged
// [RQ17] Displacement load: primary 32, 16-bit displacement
// [RQ18] Displacement sign-extended, plus nonzero base
// [RQ19] Base update only without storage fault
// [RQ20] Zero high word on 64-bit implementation
// [RQ21] Reservation lost on foreign write or store
`ifndef WLU_DEFS_VH
`define WLU_DEFS_VH
`define WLU_OP_X        6'h1F
`define WLU_OP_DISP     6'h20
`define WLU_XO_RESERVE  10'h014
`define WLU_XO_ALG_UPD  10'h175
`define WLU_XO_ALG_IDX  10'h155
`define WLU_XO_BREV     10'h216
`define WLU_REG_ZERO    5'h00
`define WLU_ALIGN_MASK  2'h3
// Instruction field positions, bit 31 is the most significant
`define WLU_F_OP        31:26
`define WLU_F_DEST      25:21
`define WLU_F_BASE      20:16
`define WLU_F_INDEX     15:11
`define WLU_F_XO        10:1
`define WLU_F_RC        0
`define WLU_F_DISP      15:0
`define WLU_F_SIGN      31
`endif

/* rtl/wlu_reserve.v */
// Reservation tracker for load-and-reserve
`timescale 1ns/1ps
`include "wlu_defs.vh"
module wlu_reserve (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Events
  input  wire        set_i,
  input  wire [63:0] set_addr_i,
  input  wire        snoop_wr_i,
  input  wire [63:0] snoop_addr_i,
  input  wire        cond_done_i,
  input  wire [63:0] cond_addr_i,
  // State
  output reg         valid_o,
  output reg  [63:0] addr_o,
  output wire        cond_ok_o
);
  wire snoop_hit;

  // Foreign write to the reserved word
  assign snoop_hit = snoop_wr_i && (snoop_addr_i[63:2] == addr_o[63:2]);
  // Store may go ahead only on an intact reservation of the same word
  assign cond_ok_o = valid_o && !snoop_hit && (cond_addr_i[63:2] == addr_o[63:2]); // RQ4

  // Set wins over any clear in the same cycle
  always @(posedge clock_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      addr_o  <= 64'h0000000000000000;
    end else if (set_i) begin
      valid_o <= 1'b1;                                                  // RQ3
      addr_o  <= set_addr_i;
    end else if (snoop_hit || cond_done_i) begin
      valid_o <= 1'b0;                                                  // RQ21
    end
  end
endmodule // wlu_reserve

/* rtl/wlu_top.v */
// Word-load instruction unit: decode, address, storage access, writeback
`timescale 1ns/1ps
`include "wlu_defs.vh"
module wlu_top (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Configuration
  input  wire        mode64_i,
  // Issue
  input  wire        issue_valid_i,
  input  wire [31:0] instr_i,
  output wire        issue_ready_o,
  // Register file read ports
  output wire [4:0]  base_register_o,
  output wire [4:0]  index_register_o,
  input  wire [63:0] base_data_i,
  input  wire [63:0] index_data_i,
  // Storage request
  output reg         mem_req_o,
  output reg  [63:0] effective_address_o,
  input  wire        mem_ack_i,
  input  wire [31:0] mem_data_i,
  input  wire        mem_align_fault_i,
  input  wire        mem_dsi_fault_i,
  // Snoop from other agents
  input  wire        snoop_wr_i,
  input  wire [63:0] snoop_addr_i,
  // Conditional store completion
  input  wire        cond_done_i,
  input  wire [63:0] cond_addr_i,
  output wire        cond_ok_o,
  output wire        resv_valid_o,
  // Destination writeback
  output reg         dest_we_o,
  output reg  [4:0]  dest_register_o,
  output reg  [63:0] dest_data_o,
  // Base update writeback
  output reg         base_we_o,
  output reg  [4:0]  base_wr_register_o,
  output reg  [63:0] base_wr_data_o,
  // Status
  output reg         illegal_o,
  output reg         fault_o,
  output wire        fixed_point_exception_we_o,
  output wire        cr0_we_o
);
  localparam ST_IDLE = 2'b01;
  localparam ST_MEM  = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [31:0] instr_q;
  reg         k_res, k_upd, k_idx, k_brev, k_disp;
  wire        d_res, d_upd, d_idx, d_brev, d_disp, d_ill;
  wire [4:0]  f_base;
  wire [63:0] disp_ext;
  wire [63:0] offset;
  wire [63:0] ea;
  wire        accept;
  wire        resv_set;
  reg  [63:0] load_value;
  wire [63:0] resv_addr;

  // Instruction field extraction
  assign f_base           = instr_i[`WLU_F_BASE];
  assign base_register_o  = f_base;
  assign index_register_o = instr_i[`WLU_F_INDEX];
  assign disp_ext = {{48{instr_i[`WLU_F_SIGN - 16]}}, instr_i[`WLU_F_DISP]}; // RQ18
  assign offset   = d_disp ? disp_ext : index_data_i;                        // RQ17

  // Effective address: base field zero means no base term
  assign ea = (f_base == `WLU_REG_ZERO) ? offset : (base_data_i + offset);    // RQ2 RQ12 RQ14 RQ18

  assign issue_ready_o = (state == ST_IDLE);
  assign accept        = issue_valid_i && issue_ready_o;
  // None of these loads touch exception or condition flags
  assign fixed_point_exception_we_o = 1'b0;                                 // RQ6 RQ16
  assign cr0_we_o                   = 1'b0;                                 // RQ16
  assign resv_set = (state == ST_MEM) && mem_ack_i && k_res
                    && !mem_align_fault_i && !mem_dsi_fault_i;               // RQ3

  wlu_decode u_dec (
    .instr_i      (instr_i),
    .mode64_i     (mode64_i),
    .is_reserve_o (d_res),
    .is_alg_upd_o (d_upd),
    .is_alg_idx_o (d_idx),
    .is_brev_o    (d_brev),
    .is_disp_o    (d_disp),
    .illegal_o    (d_ill)
  );

  wlu_reserve u_resv (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .set_i        (resv_set),
    .set_addr_i   (effective_address_o),
    .snoop_wr_i   (snoop_wr_i),
    .snoop_addr_i (snoop_addr_i),
    .cond_done_i  (cond_done_i),
    .cond_addr_i  (cond_addr_i),
    .valid_o      (resv_valid_o),
    .addr_o       (resv_addr),
    .cond_ok_o    (cond_ok_o)
  );

  // Shape the loaded word by kind
  always @* begin
    if (k_upd || k_idx) begin
      load_value = {{32{mem_data_i[31]}}, mem_data_i};                      // RQ8
    end else if (k_brev) begin
      load_value = {32'h00000000, mem_data_i[7:0], mem_data_i[15:8],
                    mem_data_i[23:16], mem_data_i[31:24]};                  // RQ15 RQ20
    end else begin
      load_value = {32'h00000000, mem_data_i};                              // RQ20
    end
  end

  // Next state
  always @* begin
    case (state)
      ST_IDLE: begin
        if (accept && (d_res || d_upd || d_idx || d_brev || d_disp)) begin
          next_state = ST_MEM;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_MEM: begin
        next_state = mem_ack_i ? ST_IDLE : ST_MEM;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer and writeback registers
  always @(posedge clock_i) begin
    if (rst_i) begin
      state               <= ST_IDLE;
      instr_q             <= 32'h00000000;
      {k_res, k_upd, k_idx, k_brev, k_disp} <= 5'h00;
      mem_req_o           <= 1'b0;
      effective_address_o <= 64'h0000000000000000;
      dest_we_o           <= 1'b0;
      dest_register_o     <= 5'h00;
      dest_data_o         <= 64'h0000000000000000;
      base_we_o           <= 1'b0;
      base_wr_register_o  <= 5'h00;
      base_wr_data_o      <= 64'h0000000000000000;
      illegal_o           <= 1'b0;
      fault_o             <= 1'b0;
    end else begin
      state     <= next_state;
      dest_we_o <= 1'b0;
      base_we_o <= 1'b0;
      illegal_o <= 1'b0;
      fault_o   <= 1'b0;
      if (accept) begin
        illegal_o <= d_ill;                                                 // RQ13
        instr_q   <= instr_i;
        {k_res, k_upd, k_idx, k_brev, k_disp} <= {d_res, d_upd, d_idx, d_brev, d_disp};
        if (next_state == ST_MEM) begin
          mem_req_o           <= 1'b1;
          effective_address_o <= ea;
        end
      end
      if ((state == ST_MEM) && mem_ack_i) begin
        mem_req_o <= 1'b0;
        if (mem_align_fault_i || mem_dsi_fault_i) begin
          fault_o <= 1'b1;                                                  // RQ19
        end else begin
          dest_we_o       <= 1'b1;                                          // RQ3
          dest_register_o <= instr_q[`WLU_F_DEST];
          dest_data_o     <= load_value;
          // Update only when base is neither zero nor the destination
          if (k_upd && (instr_q[`WLU_F_BASE] != `WLU_REG_ZERO)
              && (instr_q[`WLU_F_BASE] != instr_q[`WLU_F_DEST])) begin      // RQ10
            base_we_o          <= 1'b1;                                     // RQ9 RQ19
            base_wr_register_o <= instr_q[`WLU_F_BASE];
            base_wr_data_o     <= effective_address_o;
          end
        end
      end
    end
  end
endmodule // wlu_top
